// >>> sbc_defines.svh
// Summary of operation
// - drop frames in unsupported format for command
// - no response when frame CRC fails
// - reserved or unimplemented codes get no response
// - decode the ten supported command codes
// - finish each command before next frame
// - one reply during the following transfer
// - only init recognized until initialized
// - init data byte field layout decoded
// - reset address is preprogrammed or zero
// - invalid bank select gets no response
// - switch request one closes, zero open
// - program enable bit gates user OTP writes
// - test downstream node short, set fault
// - close switch only without fault and requested
// - blanking interval after closing the switch
// - preprogrammed: both addresses equal stored one
// - unprogrammed: frame address zero, new assigned
// - addressing failure: no assign, open, silent
// - adopt new address when conditions met
// - OTP check uses all-zero address bits
// - ignore init frames once initialized
// - ignore init assigning address zero
// - init reply reports the bus fault flag
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_CLK_PERIOD_NS    40
`define SBC_BUS_TEST_TIME_NS 2000
`define SBC_BLANK_TIME_NS    100000

`define SBC_INIT_NV_BIT      7
`define SBC_INIT_BS_BIT      6
`define SBC_INIT_BANK_HI     5
`define SBC_INIT_BANK_LO     4
`define SBC_INIT_ADDR_HI     3
`define SBC_INIT_ADDR_LO     0

`define SBC_ADDR_ZERO        4'h0
`define SBC_VALID_BANK_MASK  4'h7
`define SBC_REPLY_ZERO       16'h0000
`define SBC_REPLY_PAD        3'h0

`endif

// >>> sbc_pkg.sv
package sbc_pkg;

    typedef enum logic [3:0] {
        SBC_CMD_INIT       = 4'b0000,
        SBC_CMD_STATUS     = 4'b0001,
        SBC_CMD_ACCEL      = 4'b0010,
        SBC_CMD_RSV3       = 4'b0011,
        SBC_CMD_IDENT      = 4'b0100,
        SBC_CMD_RSV5       = 4'b0101,
        SBC_CMD_RSV6       = 4'b0110,
        SBC_CMD_CLEAR      = 4'b0111,
        SBC_CMD_RSV8       = 4'b1000,
        SBC_CMD_NVM        = 4'b1001,
        SBC_CMD_FORMAT     = 4'b1010,
        SBC_CMD_READ_REG   = 4'b1011,
        SBC_CMD_ST_OFF     = 4'b1100,
        SBC_CMD_ST_ON      = 4'b1101,
        SBC_CMD_RSVE       = 4'b1110,
        SBC_CMD_REV_INIT   = 4'b1111
    } sbc_cmd_t;

    typedef enum logic [1:0] {
        SBC_ST_IDLE  = 2'b00,
        SBC_ST_TEST  = 2'b01,
        SBC_ST_BLANK = 2'b10,
        SBC_ST_DONE  = 2'b11
    } sbc_state_t;

    typedef struct packed {
        sbc_cmd_t    cmd;
        logic [3:0]  addr;
        logic [7:0]  data;
        logic        long_frame;
        logic        enhanced;
        logic        crc_ok;
    } sbc_frame_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } sbc_reply_t;

endpackage : sbc_pkg

// >>> sbc_pin_sync.sv
`timescale 1ns/1ps
// a change is taken only once the second and third stages agree, which also
// rejects a single-cycle glitch that made it past the first stage
module sbc_pin_sync (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule : sbc_pin_sync

// >>> sbc_interval_timer.sv
`timescale 1ns/1ps
module sbc_interval_timer #(
    parameter int WIDTH = 12
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] length,
    output logic                  busy,
    output logic                  expired
);
    logic [WIDTH-1:0] remaining;
    wire              last_cycle = busy && (remaining == '0);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            remaining <= '0;
            busy      <= 1'b0;
            expired   <= 1'b0;
        end else begin
            expired <= last_cycle;
            if (start) begin
                remaining <= length - WIDTH'(1);
                busy      <= 1'b1;
            end else if (last_cycle) begin
                busy <= 1'b0;
            end else if (busy) begin
                remaining <= remaining - WIDTH'(1);
            end
        end
    end
endmodule : sbc_interval_timer

// >>> sbc_command_init.sv
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_command_init #(
    parameter int TEST_NS   = `SBC_BUS_TEST_TIME_NS,
    parameter int BLANK_NS  = `SBC_BLANK_TIME_NS,
    parameter int TIMER_W   = 16
) (
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               frame_valid,
    input  wire sbc_pkg::sbc_frame_t frame,
    input  wire logic               transfer_start,
    input  wire logic [15:0]        cmd_reply_word,
    input  wire logic [3:0]         otp_address,
    input  wire logic               otp_address_programmed,
    input  wire logic               downstream_bus_node,
    output sbc_pkg::sbc_reply_t     reply,
    output logic                    cmd_accept,
    output sbc_pkg::sbc_cmd_t       cmd_code,
    output logic [7:0]              cmd_data,
    output logic                    cmd_long,
    output logic                    ready,
    output logic                    initialized,
    output logic [3:0]              node_address,
    output logic                    bus_switch_close,
    output logic                    bus_fault_flag,
    output logic                    otp_program_enable,
    output logic [1:0]              bank_select,
    output logic [3:0]              otp_check_address
);
    // least times round up to whole cycles
    localparam int TEST_CYCLES_RAW  = (TEST_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS;
    localparam int BLANK_CYCLES_RAW = (BLANK_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS;
    localparam int TEST_CYCLES  = (TEST_CYCLES_RAW < 1) ? 1 : TEST_CYCLES_RAW;
    localparam int BLANK_CYCLES = (BLANK_CYCLES_RAW < 1) ? 1 : BLANK_CYCLES_RAW;
    localparam logic [TIMER_W-1:0] TEST_LEN  = TIMER_W'(TEST_CYCLES);
    localparam logic [TIMER_W-1:0] BLANK_LEN = TIMER_W'(BLANK_CYCLES);

    sbc_pkg::sbc_state_t state;
    sbc_pkg::sbc_state_t next_state;

    logic        bus_high;
    logic        timer_busy;
    logic        timer_expired;
    logic        address_loaded;
    logic        fault_seen;
    logic        pend_switch;
    logic        pend_nv;
    logic [1:0]  pend_bank;
    logic [3:0]  pend_addr;
    logic        reply_pending;
    logic [15:0] reply_word;

    sbc_pin_sync u_bus_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pin_in   (downstream_bus_node),
        .level    (bus_high)
    );

    // ---------------- frame screening ----------------
    wire [3:0] init_new_addr = frame.data[`SBC_INIT_ADDR_HI:`SBC_INIT_ADDR_LO];
    wire [1:0] init_bank     = frame.data[`SBC_INIT_BANK_HI:`SBC_INIT_BANK_LO];
    wire       init_switch   = frame.data[`SBC_INIT_BS_BIT];
    wire       init_nv       = frame.data[`SBC_INIT_NV_BIT];

    wire is_init     = (frame.cmd == sbc_pkg::SBC_CMD_INIT);
    wire long_only   = (frame.cmd == sbc_pkg::SBC_CMD_NVM)
                    || (frame.cmd == sbc_pkg::SBC_CMD_FORMAT)
                    || (frame.cmd == sbc_pkg::SBC_CMD_READ_REG);
    wire any_format  = (frame.cmd == sbc_pkg::SBC_CMD_STATUS)
                    || (frame.cmd == sbc_pkg::SBC_CMD_ACCEL)
                    || (frame.cmd == sbc_pkg::SBC_CMD_IDENT)
                    || (frame.cmd == sbc_pkg::SBC_CMD_CLEAR)
                    || (frame.cmd == sbc_pkg::SBC_CMD_ST_OFF)
                    || (frame.cmd == sbc_pkg::SBC_CMD_ST_ON);
    // codes 3,5,6,8,E,F fall through every term and are dropped silently
    wire implemented = is_init || long_only || any_format;

    wire format_ok   = is_init   ? (frame.long_frame && !frame.enhanced)
                     : long_only ? frame.long_frame
                     : any_format;

    // frames arriving while the init sequence runs are the master's fault
    wire frame_usable = frame_valid && ready && frame.crc_ok
                     && implemented && format_ok;

    // ---------------- initialization checks ----------------
    wire [3:0] bank_bits = `SBC_VALID_BANK_MASK >> init_bank;
    wire       bank_ok   = bank_bits[0];
    wire addr_ok_pre = (frame.addr == otp_address)
                    && (init_new_addr == otp_address);
    wire addr_ok_new = (frame.addr == `SBC_ADDR_ZERO);
    wire addr_ok     = otp_address_programmed ? addr_ok_pre : addr_ok_new;
    wire addr_nonzero = (init_new_addr != `SBC_ADDR_ZERO);

    wire init_take = frame_usable && is_init && !initialized
                  && bank_ok && addr_ok && addr_nonzero;

    // ---------------- ordinary commands ----------------
    wire cmd_take = frame_usable && !is_init && initialized
                 && (frame.addr == node_address);

    // ---------------- init sequence ----------------
    wire test_done  = (state == sbc_pkg::SBC_ST_TEST) && timer_expired;
    wire close_ok   = test_done && !fault_seen && !bus_high && pend_switch;
    wire seq_finish = (test_done && !close_ok)
                   || ((state == sbc_pkg::SBC_ST_BLANK) && timer_expired);
    wire timer_start = init_take || close_ok;
    wire [TIMER_W-1:0] timer_len = close_ok ? BLANK_LEN : TEST_LEN;

    sbc_interval_timer #(
        .WIDTH (TIMER_W)
    ) u_timer (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .start    (timer_start),
        .length   (timer_len),
        .busy     (timer_busy),
        .expired  (timer_expired)
    );

    always_comb begin
        next_state = state;
        case (state)
            sbc_pkg::SBC_ST_IDLE: begin
                if (init_take) begin
                    next_state = sbc_pkg::SBC_ST_TEST;
                end
            end
            sbc_pkg::SBC_ST_TEST: begin
                if (close_ok) begin
                    next_state = sbc_pkg::SBC_ST_BLANK;
                end else if (test_done) begin
                    next_state = sbc_pkg::SBC_ST_DONE;
                end
            end
            sbc_pkg::SBC_ST_BLANK: begin
                if (timer_expired) begin
                    next_state = sbc_pkg::SBC_ST_DONE;
                end
            end
            sbc_pkg::SBC_ST_DONE: begin
                next_state = sbc_pkg::SBC_ST_DONE;
            end
            default: begin
                next_state = sbc_pkg::SBC_ST_IDLE;
            end
        endcase
    end

    // ready drops only for the test and blanking span; each command otherwise
    // completes in the cycle it is taken
    assign ready       = (state == sbc_pkg::SBC_ST_IDLE)
                      || (state == sbc_pkg::SBC_ST_DONE);
    assign initialized = (state == sbc_pkg::SBC_ST_DONE);

    // the new address never takes part in the user OTP error check
    assign otp_check_address = `SBC_ADDR_ZERO;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= sbc_pkg::SBC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // address straps are caught on the first edge after release, not in reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            address_loaded <= 1'b0;
            node_address   <= `SBC_ADDR_ZERO;
        end else if (!address_loaded) begin
            address_loaded <= 1'b1;
            node_address   <= otp_address_programmed ? otp_address
                                                     : `SBC_ADDR_ZERO;
        end else if (seq_finish) begin
            node_address <= pend_addr;
        end
    end

    // init fields are held until the sequence ends, so a failed address check
    // leaves the switch, bank and program enable untouched
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_switch <= 1'b0;
            pend_nv     <= 1'b0;
            pend_bank   <= 2'h0;
            pend_addr   <= `SBC_ADDR_ZERO;
        end else if (init_take) begin
            pend_switch <= init_switch;
            pend_nv     <= init_nv;
            pend_bank   <= init_bank;
            pend_addr   <= init_new_addr;
        end
    end

    // any high sample during the test window counts as a short
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_seen <= 1'b0;
        end else if (init_take) begin
            fault_seen <= 1'b0;
        end else if ((state == sbc_pkg::SBC_ST_TEST) && bus_high) begin
            fault_seen <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_fault_flag <= 1'b0;
        end else if (test_done) begin
            bus_fault_flag <= fault_seen || bus_high;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_switch_close <= 1'b0;
        end else if (close_ok) begin
            bus_switch_close <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otp_program_enable <= 1'b0;
            bank_select        <= 2'h0;
        end else if (seq_finish) begin
            otp_program_enable <= pend_nv;
            bank_select        <= pend_bank;
        end
    end

    // ---------------- command hand-off ----------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_accept <= 1'b0;
            cmd_code   <= sbc_pkg::SBC_CMD_INIT;
            cmd_data   <= 8'h00;
            cmd_long   <= 1'b0;
        end else begin
            cmd_accept <= cmd_take;
            if (cmd_take) begin
                cmd_code <= frame.cmd;
                cmd_data <= frame.data;
                cmd_long <= frame.long_frame;
            end
        end
    end

    // ---------------- reply ----------------
    // init reply is formed at the end of the sequence so it carries the
    // settled fault result; the next transfer start sends it once
    wire [15:0] init_reply = {pend_addr, `SBC_REPLY_PAD,
                              (fault_seen || bus_high) && test_done ? 1'b1 :
                              bus_fault_flag,
                              pend_nv, pend_switch, pend_bank, pend_addr};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_pending <= 1'b0;
            reply_word    <= `SBC_REPLY_ZERO;
        end else if (seq_finish) begin
            reply_pending <= 1'b1;
            reply_word    <= init_reply;
        end else if (cmd_take) begin
            reply_pending <= 1'b1;
            reply_word    <= cmd_reply_word;
        end else if (transfer_start) begin
            reply_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply <= '0;
        end else begin
            reply.valid <= transfer_start && reply_pending;
            if (transfer_start && reply_pending) begin
                reply.word <= reply_word;
            end
        end
    end

    wire unused_timer_busy = timer_busy;

endmodule : sbc_command_init

// >>> sbc_command_init_sva.sv
`timescale 1ns/1ps
module sbc_command_init_sva #(
    parameter int TEST_NS  = 2000,
    parameter int BLANK_NS = 100000,
    parameter int TIMER_W  = 16
) (
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic                frame_valid,
    input wire sbc_pkg::sbc_frame_t frame,
    input wire logic                transfer_start,
    input wire logic [15:0]         cmd_reply_word,
    input wire logic [3:0]          otp_address,
    input wire logic                otp_address_programmed,
    input wire logic                downstream_bus_node,
    input wire sbc_pkg::sbc_reply_t reply,
    input wire logic                cmd_accept,
    input wire sbc_pkg::sbc_cmd_t   cmd_code,
    input wire logic [7:0]          cmd_data,
    input wire logic                cmd_long,
    input wire logic                ready,
    input wire logic                initialized,
    input wire logic [3:0]          node_address,
    input wire logic                bus_switch_close,
    input wire logic                bus_fault_flag,
    input wire logic                otp_program_enable,
    input wire logic [1:0]          bank_select,
    input wire logic [3:0]          otp_check_address
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic rsv_code  = frame.cmd inside {4'h3, 4'h5, 4'h6, 4'h8, 4'hE, 4'hF};
    wire logic long_only = frame.cmd inside {4'h9, 4'hA, 4'hB};
    wire logic good_cmd  = frame_valid && ready && frame.crc_ok && initialized && !rsv_code
                           && frame.cmd != 4'h0 && frame.addr == node_address
                           && (frame.long_frame || !long_only);
    // both the bus test and the blanking hold off new frames longer than 8 cycles (blanking is 10 cycles in the testbench)
    sequence s_held_low;
        !ready [*8];
    endsequence
    sequence s_slot_then_quiet;
        $past(transfer_start) ##1 !reply.valid;
    endsequence
    a_crc_bad_drop: assert property (frame_valid && !frame.crc_ok |=> !cmd_accept)
        else $error("accept after bad crc");
    a_reserved_drop: assert property (frame_valid && rsv_code |=> !cmd_accept)
        else $error("accept of reserved code");
    a_long_only: assert property (frame_valid && long_only && !frame.long_frame |=> !cmd_accept)
        else $error("short frame accepted for long-only code");
    a_accept_code: assert property (good_cmd |=> cmd_accept && cmd_code == $past(frame.cmd))
        else $error("supported command not accepted");
    a_uninit_silent: assert property (!initialized && frame_valid |=> !cmd_accept)
        else $error("command accepted before init");
    a_addr_mismatch: assert property (frame_valid && frame.addr != node_address |=> !cmd_accept)
        else $error("accept with wrong address");
    a_switch_no_fault: assert property ($rose(bus_switch_close) |-> !bus_fault_flag)
        else $error("switch closed with bus fault");
    a_blank_hold: assert property ($rose(bus_switch_close) |-> s_held_low)
        else $error("ready during blanking");
    a_test_hold: assert property ($fell(ready) |-> s_held_low)
        else $error("bus test too short");
    a_reply_slot: assert property (reply.valid |-> s_slot_then_quiet)
        else $error("reply outside slot");
    a_init_locked: assert property (initialized |=> initialized && $stable(node_address))
        else $error("state changed after init");
    a_addr_nonzero: assert property (initialized |-> node_address != 4'h0)
        else $error("zero address assigned");
    a_check_zero: assert property (otp_check_address == 4'h0)
        else $error("check address not zero");
endmodule : sbc_command_init_sva

bind sbc_command_init sbc_command_init_sva #(.TEST_NS(TEST_NS), .BLANK_NS(BLANK_NS),
    .TIMER_W(TIMER_W)) u_sva (.core_clk, .reset_n, .frame_valid, .frame, .transfer_start,
    .cmd_reply_word, .otp_address, .otp_address_programmed, .downstream_bus_node, .reply,
    .cmd_accept, .cmd_code, .cmd_data, .cmd_long, .ready, .initialized, .node_address,
    .bus_switch_close, .bus_fault_flag, .otp_program_enable, .bank_select,
    .otp_check_address);

// >>> sbc_master_model.sv
`timescale 1ns/1ps
module sbc_master_model #(
    parameter int GAP = 4
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                go,
    input  wire sbc_pkg::sbc_frame_t req,
    output logic                     frame_valid,
    output sbc_pkg::sbc_frame_t      frame
);
    int gap;
    always @(negedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_valid <= 1'b0;
            frame       <= '0;
            gap         <= 0;
        end else if (go && gap == 0 && !frame_valid) begin
            frame_valid <= 1'b1;
            frame       <= req;
            gap         <= GAP;
        end else begin
            frame_valid <= 1'b0;
            // idle lines keep toggling so a stale frame never looks valid
            frame       <= ~frame;
            gap         <= (gap > 0) ? gap - 1 : 0;
        end
    end
endmodule : sbc_master_model

// >>> sbc_command_init_tb_top.sv
`timescale 1ns/1ps
module sbc_command_init_tb_top;
    logic                core_clk;
    logic                reset_n;
    logic                go;
    sbc_pkg::sbc_frame_t mreq;
    logic                frame_valid;
    sbc_pkg::sbc_frame_t frame;
    logic                transfer_start;
    logic [15:0]         cmd_reply_word;
    logic [3:0]          otp_address;
    logic                otp_address_programmed;
    logic                downstream_bus_node;
    sbc_pkg::sbc_reply_t reply;
    logic                cmd_accept;
    sbc_pkg::sbc_cmd_t   cmd_code;
    logic [7:0]          cmd_data;
    logic                cmd_long;
    logic                ready;
    logic                initialized;
    logic [3:0]          node_address;
    logic                bus_switch_close;
    logic                bus_fault_flag;
    logic                otp_program_enable;
    logic [1:0]          bank_select;
    logic [3:0]          otp_check_address;
    int                  err_count;
    int                  n_checks;
    int                  blank_cnt;
    logic                exp;
    logic [7:0] bd [6]  = '{8'h12, 8'h12, 8'h12, 8'h32, 8'h12, 8'h10};
    logic [3:0] ba [6]  = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0};
    logic [2:0] bf [6]  = '{3'b100, 3'b111, 3'b001, 3'b101, 3'b101, 3'b101};

    // blanking shortened to 10 cycles so the run stays short
    sbc_command_init #(.TEST_NS(2000), .BLANK_NS(400), .TIMER_W(16)) DUT (.core_clk,
        .reset_n, .frame_valid, .frame, .transfer_start, .cmd_reply_word, .otp_address,
        .otp_address_programmed, .downstream_bus_node, .reply, .cmd_accept, .cmd_code,
        .cmd_data, .cmd_long, .ready, .initialized, .node_address, .bus_switch_close,
        .bus_fault_flag, .otp_program_enable, .bank_select, .otp_check_address);
    sbc_master_model #(.GAP(4)) u_master (.core_clk, .reset_n, .go, .req(mreq),
        .frame_valid, .frame);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chkb(input logic got, input logic want);
        n_checks++;
        if (got !== want) begin
            err_count++;
            $display("mismatch at %0t: bit got %b want %b", $time, got, want);
        end
    endtask : chkb
    task automatic chkw(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            err_count++;
            $display("mismatch at %0t: word got %h want %h", $time, got, want);
        end
    endtask : chkw
    task automatic do_reset(input logic prog, input logic [3:0] strap);
        reset_n                = 1'b0;
        otp_address_programmed = prog;
        otp_address            = strap;
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask : do_reset
    // returns at the falling edge where the take is already visible
    task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
                        input logic [2:0] fl);
        // one edge first, so go never falls and rises in one time step
        @(negedge core_clk);
        mreq <= '{cmd: sbc_pkg::sbc_cmd_t'(c), addr: a, data: d, long_frame: fl[2],
                  enhanced: fl[1], crc_ok: fl[0]};
        go   <= 1'b1;
        repeat (20) begin
            @(negedge core_clk);
            if (frame_valid === 1'b1) break;
        end
        go <= 1'b0;
    endtask : send
    task automatic xfer(input logic want, input logic [15:0] word);
        int seen;
        logic [15:0] w;
        seen = 0;
        w    = 16'h0000;
        transfer_start <= 1'b1;
        @(negedge core_clk);
        transfer_start <= 1'b0;
        repeat (3) begin
            if (reply.valid === 1'b1) begin
                seen++;
                w = reply.word;
            end
            @(negedge core_clk);
        end
        chkw(16'(seen), {15'h0000, want});
        if (want) chkw(w, word);
    endtask : xfer
    task automatic wait_init();
        blank_cnt = 0;
        repeat (300) begin
            @(negedge core_clk);
            if (bus_switch_close === 1'b1 && ready === 1'b0) blank_cnt++;
            if (initialized === 1'b1) break;
        end
        chkb(initialized, 1'b1);
    endtask : wait_init
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    initial begin
        #(40 * 20000);
        err_count++;
        report_and_stop();
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        go = 1'b0;
        mreq = '0;
        transfer_start = 1'b0;
        cmd_reply_word = 16'h0000;
        downstream_bus_node = 1'b0;
        do_reset(1'b0, 4'h5);
        chkw({12'h000, node_address}, 16'h0000);
        chkw({12'h000, otp_check_address}, 16'h0000);
        send(4'h1, 4'h0, 8'h00, 3'b101);
        chkb(cmd_accept, 1'b0);
        for (int i = 0; i < 6; i++) begin
            send(4'h0, ba[i], bd[i], bf[i]);
            chkb(ready, 1'b1);
        end
        chkw({12'h000, node_address}, 16'h0000);
        xfer(1'b0, 16'h0000);
        downstream_bus_node = 1'b1;
        send(4'h0, 4'h0, 8'hDA, 3'b101);
        chkb(ready, 1'b0);
        wait_init();
        chkb(bus_fault_flag, 1'b1);
        chkb(bus_switch_close, 1'b0);
        chkw({12'h000, node_address}, 16'h000A);
        chkb(otp_program_enable, 1'b1);
        chkw({14'h0000, bank_select}, 16'h0001);
        xfer(1'b1, 16'hA1DA);
        xfer(1'b0, 16'h0000);
        downstream_bus_node = 1'b0;
        do_reset(1'b1, 4'h7);
        chkw({12'h000, node_address}, 16'h0007);
        send(4'h0, 4'h7, 8'h63, 3'b101);
        chkb(ready, 1'b1);
        send(4'h0, 4'h7, 8'h67, 3'b101);
        wait_init();
        chkb(bus_switch_close, 1'b1);
        chkb(bus_fault_flag, 1'b0);
        chkw({12'h000, node_address}, 16'h0007);
        chkb(blank_cnt >= 10, 1'b1);
        chkb(otp_program_enable, 1'b0);
        chkw({14'h0000, bank_select}, 16'h0002);
        xfer(1'b1, 16'h7067);
        send(4'h0, 4'h7, 8'h67, 3'b101);
        chkb(ready, 1'b1);
        for (int c = 0; c < 16; c++) begin
            for (int l = 0; l < 2; l++) begin
                exp = !(c inside {0, 3, 5, 6, 8, 14, 15}) && (l == 1 || !(c inside {9, 10, 11}));
                cmd_reply_word = 16'hC300 | 16'(c);
                send(4'(c), 4'h7, 8'h3C, {1'(l), 2'b01});
                chkb(cmd_accept, exp);
                if (exp) chkw({12'h000, cmd_code}, 16'(c));
                if (exp) chkw({8'h00, cmd_data}, 16'h003C);
                if (exp) chkb(cmd_long, 1'(l));
                xfer(exp, cmd_reply_word);
            end
        end
        send(4'h1, 4'h5, 8'h00, 3'b101);
        chkb(cmd_accept, 1'b0);
        send(4'h1, 4'h7, 8'h00, 3'b100);
        chkb(cmd_accept, 1'b0);
        report_and_stop();
    end
endmodule : sbc_command_init_tb_top
